// *** verilog/cfep_pipeline.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfep_pipeline (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Clock source selection, steady in operation
  input  wire cfep_pkg::cfep_src_t     src_sel,
  input  wire logic                    high_speed_crystal_source,
  input  wire logic                    low_speed_crystal_source,
  input  wire logic                    high_speed_internal_rc_source,
  input  wire logic                    low_speed_internal_rc_source,
  // Program memory
  output logic [12:0]                  pm_addr,
  output logic                         pm_rd,
  input  wire logic [15:0]             pm_data,
  // Decoder side
  input  wire cfep_pkg::cfep_dec_t     dec,
  output logic [15:0]                  insn_word,
  output logic                         insn_valid,
  // Phases and results
  output logic [3:0]                   phase,
  output logic                         phase_fetch,
  output logic                         phases_decode_execute,
  output logic                         cycle_end,
  output cfep_pkg::cfep_alu_res_t      alu_res
);
  import cfep_pkg::*;

  // ****************************************
  // Phase sequencer on a selected source
  // ****************************************
  // Sources are synchronised; a phase advances on a rising edge of the chosen one
  logic [3:0] src_s1_r, src_s2_r, src_s3_r;
  logic       src_lvl;
  logic       tick;
  logic [3:0] ph_r, ph_nxt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_s1_r <= 4'h0;
      src_s2_r <= 4'h0;
      src_s3_r <= 4'h0;
    end else begin
      src_s1_r <= {low_speed_internal_rc_source, high_speed_internal_rc_source,
                   low_speed_crystal_source, high_speed_crystal_source};
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
    end
  end

  // Change counts once second and third stages agree
  assign src_lvl  = src_s2_r[src_sel] & src_s3_r[src_sel];
  // Held level, so a glitch seen by one stage alone steps nothing

  logic src_hold_r, src_hold_nxt;
  always_comb begin
    src_hold_nxt = src_hold_r;
    if (src_s2_r[src_sel] == src_s3_r[src_sel]) begin
      src_hold_nxt = src_lvl;
    end
  end
  assign tick = src_hold_nxt & ~src_hold_r;

  always_comb begin
    ph_nxt = ph_r;
    if (tick) begin
      ph_nxt = {ph_r[2:0], ph_r[3]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_r       <= CFEP_PH_RESET;
      src_hold_r <= 1'b0;
    end else begin
      ph_r       <= ph_nxt;
      src_hold_r <= src_hold_nxt;
    end
  end

  // One-hot ring: exactly one phase high, never two
  assign phase                 = ph_r;
  assign phase_fetch           = ph_r[0];
  assign phases_decode_execute = |ph_r[3:1];
  assign cycle_end             = tick & ph_r[3];

  // ****************************************
  // Fetch / execute control
  // ****************************************
  logic [12:0] pc_r, pc_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic        iv_r, iv_nxt;
  logic        ext_r, ext_nxt;
  logic [12:0] tgt_r, tgt_nxt;
  logic        br_r, br_nxt;
  logic [15:0] fb_r, fb_nxt;
  logic        fetch_start;
  logic        taken;

  // Fetched word buffered one cycle, so memory need not hold it past the fetch phase
  assign fetch_start = tick & ph_r[3];
  // Branch decision made in execute, acted on at the next fetch edge
  assign taken = iv_r & dec.branch & dec.cond & ~ext_r;

  always_comb begin
    pc_nxt  = pc_r;
    ir_nxt  = ir_r;
    iv_nxt  = iv_r;
    ext_nxt = ext_r;
    tgt_nxt = tgt_r;
    br_nxt  = br_r;
    fb_nxt  = fb_r;
    // Word caught while the fetch strobe still stands
    if (tick & ph_r[0]) begin
      fb_nxt = pm_data;
    end
    if (tick & ph_r[1] & iv_r) begin
      // Target obtained in the cycle the branch executes
      if (taken) begin
        tgt_nxt = dec.target;
        br_nxt  = 1'b1;
      end
    end
    if (fetch_start) begin
      if (br_r) begin
        // Target fetched in the flush cycle, executed in the one after
        pc_nxt = tgt_r;
        iv_nxt = 1'b0;
        br_nxt = 1'b0;
      end else begin
        pc_nxt = pc_r + 13'h0001;
        iv_nxt = 1'b1;
      end
      if (iv_r & dec.extended & ~ext_r & ~br_r) begin
        // Second cycle of an extended word keeps it in the pipeline
        ext_nxt = 1'b1;
        pc_nxt  = pc_r;
      end else begin
        ext_nxt = 1'b0;
        ir_nxt  = fb_r;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_r  <= CFEP_PC_RESET;
      ir_r  <= CFEP_NOP_WORD;
      iv_r  <= 1'b0;
      ext_r <= 1'b0;
      tgt_r <= CFEP_PC_RESET;
      br_r  <= 1'b0;
      fb_r  <= CFEP_NOP_WORD;
    end else begin
      pc_r  <= pc_nxt;
      ir_r  <= ir_nxt;
      iv_r  <= iv_nxt;
      ext_r <= ext_nxt;
      tgt_r <= tgt_nxt;
      br_r  <= br_nxt;
      fb_r  <= fb_nxt;
    end
  end

  // Counter addresses memory; in the flush cycle it holds the target
  // Sequential word fetched beside a taken branch is simply dropped
  assign pm_addr    = pc_r;
  assign pm_rd      = ph_r[0];
  assign insn_word  = ir_r;
  assign insn_valid = iv_r;

  // ****************************************
  // Eight-bit ALU, result caught as phase four ends
  // ****************************************
  function automatic cfep_alu_res_t alu_f(input cfep_dec_t d);
    logic [8:0] s;
    s = 9'h000;
    unique case (d.alu_op)
      CFEP_ALU_ADD:  s = {1'b0, d.operand_a} + {1'b0, d.operand_b};
      CFEP_ALU_ADC:  s = {1'b0, d.operand_a} + {1'b0, d.operand_b} + {8'h00, d.carry_in};
      CFEP_ALU_SUB:  s = {1'b0, d.operand_a} - {1'b0, d.operand_b};
      CFEP_ALU_SBC:  s = {1'b0, d.operand_a} - {1'b0, d.operand_b} - {8'h00, ~d.carry_in};
      CFEP_ALU_AND:  s = {1'b0, d.operand_a & d.operand_b};
      CFEP_ALU_OR:   s = {1'b0, d.operand_a | d.operand_b};
      CFEP_ALU_XOR:  s = {1'b0, d.operand_a ^ d.operand_b};
      CFEP_ALU_CPL:  s = {1'b0, ~d.operand_a};
      CFEP_ALU_RR:   s = {1'b0, d.operand_a[0], d.operand_a[7:1]};
      CFEP_ALU_RRC:  s = {d.operand_a[0], d.carry_in, d.operand_a[7:1]};
      CFEP_ALU_RL:   s = {1'b0, d.operand_a[6:0], d.operand_a[7]};
      CFEP_ALU_RLC:  s = {d.operand_a[7], d.operand_a[6:0], d.carry_in};
      CFEP_ALU_INC:  s = {1'b0, d.operand_a} + 9'h001;
      CFEP_ALU_DEC:  s = {1'b0, d.operand_a} - 9'h001;
      default:       s = {1'b0, d.operand_a};
    endcase
    // Subtract carry is inverted borrow, so set means no borrow
    if (d.alu_op == CFEP_ALU_SUB || d.alu_op == CFEP_ALU_SBC) begin
      s[8] = ~s[8];
    end
    alu_f = '{result: s[7:0], carry: s[8], zero: (s[7:0] == 8'h00)};
  endfunction : alu_f

  cfep_alu_res_t alu_r, alu_nxt;
  always_comb begin
    alu_nxt = alu_r;
    if (fetch_start & iv_r) begin
      alu_nxt = alu_f(dec);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alu_r <= '0;
    end else begin
      alu_r <= alu_nxt;
    end
  end

  assign alu_res = alu_r;

endmodule : cfep_pipeline
`default_nettype wire

// *** verilog/cfep_pkg.sv ***
// Overview of operation
// - The system clock is split into four phases that never overlap, one active at a time.
// - The program counter advances at the start of the fetch phase, when the next word is fetched.
// - Phases two to four decode and execute the instruction held in the pipeline.
// - One full pass through the four phases is one instruction cycle.
// - The next word is fetched in the same cycle in which the current one executes.
// - A standard instruction takes one cycle and an extended one takes two, branch penalty apart.
// - Any instruction that changes the program counter takes one extra cycle.
// - A jump or call takes two cycles: one to obtain the target, one to branch.
// - Arithmetic, logic, rotate and step operations run in an eight-bit ALU; branch decisions take the decoder's cond bit.
package cfep_pkg;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          CFEP_PC_W      = 13;
  localparam int          CFEP_INSN_W    = 16;
  localparam int          CFEP_DATA_W    = 8;
  localparam logic [12:0] CFEP_PC_RESET  = 13'h0000;
  localparam logic [15:0] CFEP_NOP_WORD  = 16'h0000;
  localparam logic [3:0]  CFEP_PH_RESET  = 4'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CFEP_SRC_HI_XTAL_SEL,
    CFEP_SRC_LO_XTAL_SEL,
    CFEP_SRC_HI_RC_SEL,
    CFEP_SRC_LO_RC_SEL
  } cfep_src_t;

  typedef enum logic [3:0] {
    CFEP_ALU_ADD, CFEP_ALU_ADC, CFEP_ALU_SUB, CFEP_ALU_SBC,
    CFEP_ALU_AND, CFEP_ALU_OR,  CFEP_ALU_XOR, CFEP_ALU_CPL,
    CFEP_ALU_RR,  CFEP_ALU_RRC, CFEP_ALU_RL,  CFEP_ALU_RLC,
    CFEP_ALU_INC, CFEP_ALU_DEC, CFEP_ALU_PASS
  } cfep_alu_op_t;

  // Decoded view of the word in the pipeline, from the core decoder
  typedef struct packed {
    logic         extended;
    logic         branch;
    logic         cond;
    logic [12:0]  target;
    cfep_alu_op_t alu_op;
    logic [7:0]   operand_a;
    logic [7:0]   operand_b;
    logic         carry_in;
  } cfep_dec_t;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       zero;
  } cfep_alu_res_t;

endpackage : cfep_pkg

// *** verification/cfep_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfep_props (
  // Watched ports
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic [12:0]             pm_addr,
  input wire logic                    pm_rd,
  input wire logic [15:0]             insn_word,
  input wire logic                    insn_valid,
  input wire logic [3:0]              phase,
  input wire logic                    phase_fetch,
  input wire logic                    phases_decode_execute,
  input wire logic                    cycle_end,
  input wire cfep_pkg::cfep_alu_res_t alu_res
);
  import cfep_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_step; $rose(phase[0]); endsequence
  property p_onehot; $onehot(phase); endproperty
  property p_ring; !$stable(phase) |-> $past(phase) == {phase[0], phase[3:1]}; endproperty
  property p_fetch; pm_rd == phase[0] && phase_fetch == phase[0]; endproperty
  property p_dex; phases_decode_execute == |phase[3:1]; endproperty
  property p_hold; phases_decode_execute && $past(phases_decode_execute) |-> $stable(insn_word);
  endproperty
  property p_valid; $changed(insn_valid) |-> s_step; endproperty
  property p_alu; $changed(alu_res) |-> s_step; endproperty
  property p_end; cycle_end |-> phase[3] || (phase[0] && $past(phase[3])); endproperty
  // Address moves only with a phase step, never mid-phase
  property p_addr; !$stable(pm_addr) |-> !$stable(phase); endproperty
  a_onehot: assert property (p_onehot) else $error("phase not one-hot");
  a_ring: assert property (p_ring) else $error("phase order broken");
  a_fetch: assert property (p_fetch) else $error("fetch strobe off phase");
  a_dex: assert property (p_dex) else $error("execute phases wrong");
  a_hold: assert property (p_hold) else $error("word changed mid cycle");
  a_valid: assert property (p_valid) else $error("valid moved off cycle end");
  a_alu: assert property (p_alu) else $error("alu result moved off cycle end");
  a_end: assert property (p_end) else $error("cycle end misplaced");
  a_addr: assert property (p_addr) else $error("address moved mid phase");
endmodule : cfep_props
bind cfep_pipeline cfep_props i_props (.clk(clk), .resetn(resetn), .pm_addr(pm_addr),
  .pm_rd(pm_rd), .insn_word(insn_word), .insn_valid(insn_valid), .phase(phase),
  .phase_fetch(phase_fetch), .phases_decode_execute(phases_decode_execute),
  .cycle_end(cycle_end), .alu_res(alu_res));
`default_nettype wire

// *** verification/cfep_pmem.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfep_pmem (
  // Fetch port
  input  wire logic [12:0] pm_addr,
  input  wire logic        pm_rd,
  output logic [15:0]      pm_data
);
  // Word carries its own address, so a wrong fetch shows at once
  // Outside the fetch strobe the bus shows the inverse, so a late sample fails
  assign pm_data = pm_rd ? {3'b101, pm_addr} : ~{3'b101, pm_addr};
endmodule : cfep_pmem
`default_nettype wire

// *** verification/cfep_pipeline_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfep_pipeline_tb;
  import cfep_pkg::*;
  logic clk, resetn, pm_rd, insn_valid, cycle_end;
  logic [3:0] src_lv, phase;
  logic [12:0] pm_addr, exp_pc;
  logic [15:0] pm_data, insn_word;
  cfep_src_t src_sel;
  cfep_dec_t dec;
  cfep_alu_res_t alu_res;
  int errors, total_checks, cyc_n;
  // ****************************************
  // Harness
  // ****************************************
  cfep_pipeline i_dut (.clk(clk), .resetn(resetn), .src_sel(src_sel),
    .high_speed_crystal_source(src_lv[0]), .low_speed_crystal_source(src_lv[1]),
    .high_speed_internal_rc_source(src_lv[2]), .low_speed_internal_rc_source(src_lv[3]),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .dec(dec), .insn_word(insn_word),
    .insn_valid(insn_valid), .phase(phase), .phase_fetch(), .phases_decode_execute(),
    .cycle_end(cycle_end), .alu_res(alu_res));
  cfep_pmem i_pmem (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (cycle_end) begin
      cyc_n++;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Source kept far slower than clk so each rise is one step
  task automatic tick(input int s);
    src_lv[s] = 1'b1;
    repeat (6) @(negedge clk);
    src_lv[s] = 1'b0;
    repeat (6) @(negedge clk);
  endtask : tick
  task automatic nxt();
    int n0;
    n0 = cyc_n;
    repeat (4) tick(int'(src_sel));
    chk(16'(cyc_n - n0), 16'h0001);
    chk(insn_valid, 16'h1);
    chk(insn_word, {3'b101, exp_pc});
    exp_pc++;
  endtask : nxt
  task automatic t_src();
    logic [3:0] p;
    for (int s = 0; s < 4; s++) begin
      src_sel = cfep_src_t'(s);
      p = phase;
      tick((s + 1) % 4);
      chk(phase, p);
      tick(s);
      chk(phase, {p[2:0], p[3]});
    end
    chk(insn_word, 16'hA000);
    exp_pc = 13'h0001;
  endtask : t_src
  task automatic t_alu();
    logic [9:0] exp [16] = '{10'h046, 10'h04A, 10'h33E, 10'h33E, 10'h080, 10'h3C4, 10'h344,
      10'h03C, 10'h1E0, 10'h3E0, 10'h384, 10'h386, 10'h3C4, 10'h3BC, 10'h3C0, 10'h003};
    cfep_alu_op_t ops [16] = '{CFEP_ALU_ADD, CFEP_ALU_ADC, CFEP_ALU_SUB, CFEP_ALU_SBC,
      CFEP_ALU_AND, CFEP_ALU_OR, CFEP_ALU_XOR, CFEP_ALU_CPL, CFEP_ALU_RR, CFEP_ALU_RRC,
      CFEP_ALU_RL, CFEP_ALU_RLC, CFEP_ALU_INC, CFEP_ALU_DEC, CFEP_ALU_PASS, CFEP_ALU_SUB};
    for (int i = 0; i < 16; i++) begin
      dec = '0;
      dec.alu_op = ops[i];
      dec.operand_a = 8'hF0;
      dec.operand_b = (i == 15) ? 8'hF0 : 8'h21;
      dec.carry_in = 1'b1;
      nxt();
      chk({alu_res.result, alu_res.carry, alu_res.zero}, exp[i]);
    end
    dec = '0;
  endtask : t_alu
  task automatic t_br(input logic c);
    dec = '0;
    dec.branch = 1'b1;
    dec.cond = c;
    dec.target = 13'h0040;
    if (c) begin
      repeat (4) tick(int'(src_sel));
      dec = '0;
      chk(insn_valid, 16'h0);
      exp_pc = 13'h0040;
    end
    nxt();
    dec = '0;
    nxt();
  endtask : t_br
  task automatic t_ext();
    logic [15:0] w;
    w = insn_word;
    dec = '0;
    dec.extended = 1'b1;
    repeat (4) tick(int'(src_sel));
    dec = '0;
    chk(insn_word, w);
    nxt();
  endtask : t_ext
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    src_sel = CFEP_SRC_HI_XTAL_SEL;
    src_lv = 4'h0;
    dec = '0;
    exp_pc = 13'h0000;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_src();
    nxt();
    t_alu();
    t_br(1'b0);
    t_br(1'b1);
    t_ext();
    test_done();
  end
  initial begin
    #150000;
    errors++;
    test_done();
  end
endmodule : cfep_pipeline_tb
`default_nettype wire
